// ### fault_policy_defines.vh
// Constants for the expansion input fault policy block.
// Assumes a single 100 MHz clock and a Wishbone classic master.
// Summary of operation
// - Healthy input or display-only gives nothing
// - Open alarm input: alarm stopped, lockout running
// - Open wait input: waiting only when running
// - Open warning input: alert, never transition
// - Open permissive input: pilot from main fuel
// - Off-after-main-on: waiting, purge, reignite, pilot
// - Airflow proving input goes to airflow logic
// - Redundant input follows first communicating slot
// - Lost redundant slot never stops controller
// - Out of range raises invalid alarm response, except in warning mode
// - Analog alarm trip: alarm stopped, lockout running
// - Analog wait trip: waiting only when running
// - Analog warning trip: alert only
// - Analog permissive trip: pilot from main fuel
// - Valid strictly between low and high trip
`ifndef FAULT_POLICY_DEFINES_VH
`define FAULT_POLICY_DEFINES_VH
`define MODE_ALARM 3'h0
`define MODE_WAIT 3'h1
`define MODE_WARN 3'h2
`define MODE_MAIN 3'h3
`define MODE_DISP 3'h4
`define MODE_AIRFLOW 3'h5
`define MODE_PID 3'h6
`define CST_STOPPED 2'h0
`define CST_RUNNING 2'h1
`define CST_MAIN 2'h2
`define TR_NONE 3'h0
`define TR_ALARM 3'h1
`define TR_LOCKOUT 3'h2
`define TR_WAITING 3'h3
`define TR_PILOT 3'h4
`define TR_RELIGHT 3'h5
`define TR_AIRFLOW 3'h6
`define AL_NONE 4'h0
`define AL_DI_ALARM 4'h1
`define AL_DI_WAIT 4'h2
`define AL_DI_WARN 4'h3
`define AL_DI_MAIN 4'h4
`define AL_INVALID 4'h5
`define AL_LO_ALARM 4'h6
`define AL_HI_ALARM 4'h7
`define AL_LO_WAIT 4'h8
`define AL_HI_WAIT 4'h9
`define AL_LO_WARN 4'ha
`define AL_HI_WARN 4'hb
`define AL_LO_MAIN 4'hc
`define AL_HI_MAIN 4'hd
`define ADR_CFG 5'h00
`define ADR_LOTRIP 5'h04
`define ADR_HITRIP 5'h08
`define ADR_RESULT 5'h0c
`define ADR_IRQ_ST 5'h10
`define ADR_IRQ_MSK 5'h14
`define CFG_RST 5'h00
`define LOTRIP_RST 16'h0000
`define HITRIP_RST 16'hffff
`endif

// ### expansion_input_fault_policy.v
// Fault policy for one logical expansion input with two redundant slots.
// Assumes slot inputs and controller state arrive asynchronously; all are synchronised.
//
// Chosen here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ns
`include "fault_policy_defines.vh"
module expansion_input_fault_policy (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire [1:0] slot_comm_i,
  input wire [1:0] slot_di_i,
  input wire [31:0] slot_ai_i,
  input wire [1:0] slot_oor_i,
  input wire [1:0] ctrl_state_i,
  output reg [2:0] transition_o,
  output reg [3:0] alert_o,
  output reg airflow_sel_o,
  output reg irq_o
);
  // Register map on the low five address bits:
  //   cfg: mode [2:0], analog [3], relight after main on [4]
  //   low trip and high trip: 16-bit thresholds on lanes 0 and 1
  //   result: owner [11:10], airflow [9], alert [8:5], transition [2:0]
  //   status: alarm, lockout, waiting, pilot request; cleared by a read
  //   mask: same layout as status
  reg [4:0] cfg_reg;
  reg [15:0] lotrip_reg;
  reg [15:0] hitrip_reg;
  reg [3:0] irq_st_reg;
  reg [3:0] irq_st_next;
  reg [3:0] irq_msk_reg;
  reg [1:0] comm_s1_reg, comm_s2_reg;
  reg [1:0] di_s1_reg, di_s2_reg;
  reg [31:0] ai_s1_reg, ai_s2_reg;
  reg [1:0] oor_s1_reg, oor_s2_reg;
  reg [1:0] cst_s1_reg, cst_s2_reg;
  reg [31:0] ai_s3_reg;
  reg [1:0] cst_s3_reg;
  reg [31:0] ai_word_reg;
  reg [1:0] cst_word_reg;
  reg [1:0] owner_reg;
  reg [2:0] tr_next;
  reg [3:0] al_next;
  wire [2:0] mode = cfg_reg[2:0];
  wire analog = cfg_reg[3];
  wire relight = cfg_reg[4];

  // Stopped or running decides between alarm and lockout
  function [2:0] stop_trip;
    input [1:0] st;
    begin
      stop_trip = (st == `CST_STOPPED) ? `TR_ALARM : `TR_LOCKOUT;
    end
  endfunction

  // Waiting only pulls a running controller aside
  function [2:0] wait_tr;
    input [1:0] st;
    begin
      wait_tr = (st == `CST_STOPPED) ? `TR_NONE : `TR_WAITING;
    end
  endfunction

  // Loss of main permissive matters only on main fuel
  function [2:0] main_tr;
    input [1:0] st;
    input pilot_off;
    begin
      if (st != `CST_MAIN)
        main_tr = `TR_NONE;
      else if (pilot_off)
        main_tr = `TR_RELIGHT;
      else
        main_tr = `TR_PILOT;
    end
  endfunction

  // Trip alerts come in low and high pairs per mode
  function [3:0] ai_alert;
    input [2:0] md;
    input low;
    begin
      case (md)
        `MODE_ALARM: ai_alert = low ? `AL_LO_ALARM : `AL_HI_ALARM;
        `MODE_WAIT: ai_alert = low ? `AL_LO_WAIT : `AL_HI_WAIT;
        `MODE_WARN: ai_alert = low ? `AL_LO_WARN : `AL_HI_WARN;
        `MODE_MAIN: ai_alert = low ? `AL_LO_MAIN : `AL_HI_MAIN;
        default: ai_alert = `AL_NONE;
      endcase
    end
  endfunction

  // Offset decode shared by the write and clear-on-read paths
  function [5:0] reg_decode;
    input [4:0] a;
    begin
      reg_decode = 6'h00;
      case (a)
        `ADR_CFG: reg_decode = 6'h01;
        `ADR_LOTRIP: reg_decode = 6'h02;
        `ADR_HITRIP: reg_decode = 6'h04;
        `ADR_RESULT: reg_decode = 6'h08;
        `ADR_IRQ_ST: reg_decode = 6'h10;
        `ADR_IRQ_MSK: reg_decode = 6'h20;
        default: reg_decode = 6'h00;
      endcase
    end
  endfunction

  // Synchronisers: first stage read only by second
  always @(posedge clk_i) begin
    comm_s1_reg <= slot_comm_i;
    comm_s2_reg <= comm_s1_reg;
    di_s1_reg <= slot_di_i;
    di_s2_reg <= di_s1_reg;
    ai_s1_reg <= slot_ai_i;
    ai_s2_reg <= ai_s1_reg;
    oor_s1_reg <= slot_oor_i;
    oor_s2_reg <= oor_s1_reg;
    cst_s1_reg <= ctrl_state_i;
    cst_s2_reg <= cst_s1_reg;
  end

  // Multi-bit words cross bit by bit, so one edge can catch a torn word.
  // A word is taken once two samples agree; a word never steady is never taken.
  always @(posedge clk_i) begin
    ai_s3_reg <= ai_s2_reg;
    cst_s3_reg <= cst_s2_reg;
    if (rst_i) begin
      ai_word_reg <= 32'h00000000;
      cst_word_reg <= `CST_STOPPED;
    end else begin
      if (ai_s2_reg == ai_s3_reg)
        ai_word_reg <= ai_s2_reg;
      if (cst_s2_reg == cst_s3_reg)
        cst_word_reg <= cst_s2_reg;
    end
  end

  // Ownership latches on first slot to communicate; slot 0 wins a tie
  // A dead owner freezes the input; the spare slot is never promoted
  always @(posedge clk_i) begin
    if (rst_i) begin
      owner_reg <= 2'h0;
    end else if (owner_reg == 2'h0) begin
      if (comm_s2_reg[0])
        owner_reg <= 2'h1;
      else if (comm_s2_reg[1])
        owner_reg <= 2'h2;
    end
  end

  // Only owner slot is looked at; other slot loss is ignored
  wire sel1 = owner_reg[1];
  wire have = owner_reg != 2'h0;
  wire o_di = sel1 ? di_s2_reg[1] : di_s2_reg[0];
  wire [15:0] o_ai = sel1 ? ai_word_reg[31:16] : ai_word_reg[15:0];
  wire o_oor = sel1 ? oor_s2_reg[1] : oor_s2_reg[0];
  wire lo_trip = o_ai <= lotrip_reg;
  wire hi_trip = o_ai >= hitrip_reg;
  wire [1:0] cst = cst_word_reg;

  always @* begin
    tr_next = `TR_NONE;
    al_next = `AL_NONE;
    if (!have || mode == `MODE_DISP || mode == `MODE_PID) begin
      tr_next = `TR_NONE;
    end else if (mode == `MODE_AIRFLOW) begin
      tr_next = `TR_AIRFLOW;
    end else if (!analog) begin
      if (!o_di) begin
        case (mode)
          `MODE_ALARM: begin
            tr_next = stop_trip(cst);
            al_next = `AL_DI_ALARM;
          end
          `MODE_WAIT: begin
            tr_next = wait_tr(cst);
            al_next = `AL_DI_WAIT;
          end
          `MODE_WARN: begin
            al_next = `AL_DI_WARN;
          end
          `MODE_MAIN: begin
            tr_next = main_tr(cst, relight);
            al_next = `AL_DI_MAIN;
          end
          default: begin
            tr_next = `TR_NONE;
          end
        endcase
      end
    end else if (o_oor && mode != `MODE_WARN) begin
      // Out of range outranks trips; warning mode ignores it
      tr_next = stop_trip(cst);
      al_next = `AL_INVALID;
    end else if (!o_oor && (lo_trip || hi_trip)) begin
      case (mode)
        `MODE_ALARM: begin
          tr_next = stop_trip(cst);
          al_next = ai_alert(mode, lo_trip);
        end
        `MODE_WAIT: begin
          tr_next = wait_tr(cst);
          al_next = ai_alert(mode, lo_trip);
        end
        `MODE_WARN: begin
          al_next = ai_alert(mode, lo_trip);
        end
        `MODE_MAIN: begin
          tr_next = main_tr(cst, relight);
          al_next = ai_alert(mode, lo_trip);
        end
        default: begin
          tr_next = `TR_NONE;
        end
      endcase
    end
  end

  // Ack cycle masks the request so one access is taken once
  wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire bus_wr = bus_req && wb_we_i;
  wire [5:0] hit = reg_decode(wb_adr_i[4:0]);
  wire st_rd = bus_req && !wb_we_i && hit[4];
  // Events fire in the cycle a request first appears, not while it stands
  wire ev_alarm = tr_next == `TR_ALARM && transition_o != `TR_ALARM;
  wire ev_lockout = tr_next == `TR_LOCKOUT && transition_o != `TR_LOCKOUT;
  wire ev_wait = tr_next == `TR_WAITING && transition_o != `TR_WAITING;
  wire ev_pilot = (tr_next == `TR_PILOT || tr_next == `TR_RELIGHT) && tr_next != transition_o;
  wire [3:0] ev = {ev_pilot, ev_wait, ev_lockout, ev_alarm};

  always @* begin
    irq_st_next = irq_st_reg;
    if (st_rd)
      irq_st_next = 4'h0;
    // Set beats clear-on-read
    irq_st_next = irq_st_next | ev;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      transition_o <= `TR_NONE;
      alert_o <= `AL_NONE;
      airflow_sel_o <= 1'b0;
      irq_st_reg <= 4'h0;
      irq_o <= 1'b0;
    end else begin
      transition_o <= tr_next;
      alert_o <= al_next;
      airflow_sel_o <= (mode == `MODE_AIRFLOW) && have;
      irq_st_reg <= irq_st_next;
      // Next status, so a new event reaches irq with its status bit
      irq_o <= |(irq_st_next & irq_msk_reg);
    end
  end

  // Wishbone slave, ack one cycle after strobe
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      cfg_reg <= `CFG_RST;
      lotrip_reg <= `LOTRIP_RST;
      hitrip_reg <= `HITRIP_RST;
      irq_msk_reg <= 4'h0;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_wr) begin
        if (hit[0] && wb_sel_i[0])
          cfg_reg <= wb_dat_i[4:0];
        if (hit[1] && wb_sel_i[0])
          lotrip_reg[7:0] <= wb_dat_i[7:0];
        if (hit[1] && wb_sel_i[1])
          lotrip_reg[15:8] <= wb_dat_i[15:8];
        if (hit[2] && wb_sel_i[0])
          hitrip_reg[7:0] <= wb_dat_i[7:0];
        if (hit[2] && wb_sel_i[1])
          hitrip_reg[15:8] <= wb_dat_i[15:8];
        if (hit[5] && wb_sel_i[0])
          irq_msk_reg <= wb_dat_i[3:0];
      end
      // Result shows the registered outputs, one cycle behind the policy
      if (bus_req && !wb_we_i) begin
        case (wb_adr_i[4:0])
          `ADR_CFG: wb_dat_o <= {27'h0, cfg_reg};
          `ADR_LOTRIP: wb_dat_o <= {16'h0, lotrip_reg};
          `ADR_HITRIP: wb_dat_o <= {16'h0, hitrip_reg};
          `ADR_RESULT: wb_dat_o <= {20'h0, owner_reg, airflow_sel_o, alert_o, 2'h0, transition_o};
          `ADR_IRQ_ST: wb_dat_o <= {28'h0, irq_st_reg};
          `ADR_IRQ_MSK: wb_dat_o <= {28'h0, irq_msk_reg};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // expansion_input_fault_policy

// ### field_sensor_model.sv
// Field switches and transmitters on two redundant card slots.
// Assumes the bench sets one reading; slot 1 shows it, slot 0 the opposite.
`timescale 1ns/1ns
module field_sensor_model (
  input wire [1:0] comm_i,
  input wire di_on_i,
  input wire [15:0] value_i,
  input wire oor_i,
  output wire [1:0] slot_comm_o,
  output wire [1:0] slot_di_o,
  output wire [31:0] slot_ai_o,
  output wire [1:0] slot_oor_o
);
  assign slot_comm_o = comm_i;
  // Slot 0 disagrees, so following the wrong slot shows at once
  assign slot_di_o = {di_on_i, ~di_on_i};
  assign slot_ai_o = {value_i, ~value_i};
  assign slot_oor_o = {oor_i, ~oor_i};
endmodule // field_sensor_model

// ### fault_policy_checker.sv
// Checker on the fault policy outputs and bus handshake.
// Assumes one clock with a synchronous active-high reset.
`timescale 1ns/1ns
`include "fault_policy_defines.vh"
module fault_policy_checker (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire [2:0] transition_o,
  input wire [3:0] alert_o,
  input wire airflow_sel_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  AST_WARN: assert property (alert_o inside {`AL_DI_WARN, `AL_LO_WARN, `AL_HI_WARN} |-> !transition_o)
    else $error("warning moved");
  AST_WAIT: assert property (transition_o == `TR_WAITING |-> alert_o inside {4'h2, 4'h8, 4'h9})
    else $error("bad wait");
  AST_STOP: assert property (transition_o inside {3'h1, 3'h2} |-> alert_o inside {4'h1, [4'h5:4'h7]})
    else $error("bad stop");
  AST_PILOT: assert property (transition_o inside {3'h4, 3'h5} |-> alert_o inside {4'h4, 4'hc, 4'hd})
    else $error("bad pilot");
  AST_QUIET: assert property (!alert_o && !airflow_sel_o |-> !transition_o) else $error("move no alert");
  AST_AIRFLOW: assert property (airflow_sel_o |-> transition_o == `TR_AIRFLOW) else $error("airflow");
endmodule // fault_policy_checker
bind expansion_input_fault_policy fault_policy_checker chk_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .transition_o(transition_o), .alert_o(alert_o),
  .airflow_sel_o(airflow_sel_o));

// ### tb.sv
// Bench: policy table, registers, interrupt and redundant slots.
// Assumes outputs settle within 8 cycles of an input change.
`timescale 1ns/1ns
`include "fault_policy_defines.vh"
module tb;
  reg clk_i = 1'h0, rst_i = 1'h1, cyc = 1'h0, we = 1'h0, di = 1'h1, oo = 1'h0;
  reg [5:0] adr = 6'h0;
  reg [31:0] wd = 32'h0, rd, r;
  reg [1:0] cs = 2'h0, comm = 2'h2;
  reg [3:0] sel = 4'h0;
  reg [15:0] val = 16'h0;
  reg [7:0] q[$];
  wire ack, af, irq;
  wire [31:0] dat, ai;
  wire [2:0] tr;
  wire [3:0] al;
  wire [1:0] wc, wdi, wo;
  integer bad_count = 0, total_checks = 0, seed = 68, n = 0, m, s, l, p, ia;
  always #5 clk_i = ~clk_i;
  field_sensor_model sens (.comm_i(comm), .di_on_i(di), .value_i(val), .oor_i(oo),
    .slot_comm_o(wc), .slot_di_o(wdi), .slot_ai_o(ai), .slot_oor_o(wo));
  expansion_input_fault_policy uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(dat), .wb_ack_o(ack), .slot_comm_i(wc),
    .slot_di_i(wdi), .slot_ai_i(ai), .slot_oor_i(wo), .ctrl_state_i(cs), .transition_o(tr), .alert_o(al),
    .airflow_sel_o(af), .irq_o(irq));
  task chk(input string nm, input [31:0] sn, input [31:0] ex);
    total_checks = total_checks + 1;
    if (sn !== ex) begin
      bad_count = bad_count + 1;
      $display("MISMATCH %s expected %h seen %h", nm, ex, sn);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task wb(input w, input [4:0] a, input [31:0] d);
    @(posedge clk_i);
    cyc <= 1'h1;
    we <= w;
    sel <= 4'hf;
    adr <= {1'h0, a};
    wd <= d;
    @(posedge clk_i);
    while (ack !== 1'h1) @(posedge clk_i);
    rd = dat;
    cyc <= 1'h0;
    sel <= 4'h0;
  endtask
  function [7:0] expect_of(input [2:0] md, input an, pf, input [1:0] c, lv);
    reg [2:0] t;
    t = (md == `MODE_ALARM) ? (c ? `TR_LOCKOUT : `TR_ALARM) : `TR_NONE;
    if (md == `MODE_WAIT && c) t = `TR_WAITING;
    if (md == `MODE_MAIN && c == `CST_MAIN) t = pf ? `TR_RELIGHT : `TR_PILOT;
    if (md > `MODE_MAIN || !lv || (lv == 2'h3 && md == `MODE_WARN)) expect_of = 8'h0;
    else if (lv == 2'h3) expect_of = {c ? `TR_LOCKOUT : `TR_ALARM, `AL_INVALID, 1'h0};
    else expect_of = {t, an ? 4'h6 + {md[1:0], 1'h0} + {3'h0, lv[1]} : 4'h1 + {2'h0, md[1:0]}, 1'h0};
  endfunction
  task run_case(input [2:0] md, input an, pf, input [1:0] c, lv);
    wb(1'h1, `ADR_CFG, {27'h0, pf, an, md});
    r = {$random(seed)} % 32'hdffe;
    cs <= c;
    di <= !lv;
    oo <= lv == 2'h3;
    val <= lv == 2'h1 ? 16'h1000 : lv == 2'h2 ? 16'hf000 : 16'h1001 + r[15:0];
    repeat (8) @(posedge clk_i);
    q.push_back(expect_of(md, an, pf, c, lv));
  endtask
  // Judge once per edge; the timeout ends a hung bus wait
  always @(posedge clk_i) begin
    n = n + 1;
    if (q.size() > 0) chk("policy", {tr, al, af}, q.pop_front());
    if (n == 10000) begin
      bad_count = bad_count + 1;
      complete_run;
    end
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'h0;
    repeat (8) @(posedge clk_i);
    comm <= 2'h3;
    wb(1'h0, `ADR_HITRIP, 32'h0);
    chk("high trip", rd[15:0], `HITRIP_RST);
    wb(1'h0, 5'h18, 32'h0);
    chk("unmapped", rd, 32'h0);
    $display("register test done");
    wb(1'h1, `ADR_LOTRIP, 32'h1000);
    wb(1'h1, `ADR_HITRIP, 32'hf000);
    for (m = 0; m < 7; m = m + 1)
      for (p = 0; p < 2; p = p + 1)
        for (s = 0; s < 4; s = s + 1)
          for (l = 0; l < 2 + 2 * p; l = l + 1)
            if (m != 5) run_case(m[2:0], p[0], p[0] ^ l[1], s[1:0], l[1:0]);
    wb(1'h1, `ADR_CFG, 32'h5);
    repeat (8) @(posedge clk_i);
    chk("airflow", {af, tr}, {1'h1, `TR_AIRFLOW});
    $display("policy table done");
    run_case(`MODE_ALARM, 1'h0, 1'h0, `CST_STOPPED, 2'h0);
    wb(1'h1, `ADR_IRQ_MSK, 32'h0);
    wb(1'h0, `ADR_IRQ_ST, 32'h0);
    run_case(`MODE_ALARM, 1'h0, 1'h0, `CST_STOPPED, 2'h1);
    ia = irq;
    wb(1'h1, `ADR_IRQ_MSK, 32'hf);
    repeat (2) @(posedge clk_i);
    chk("irq masked", ia, 32'h0);
    chk("irq mask", irq, 32'h1);
    wb(1'h0, `ADR_IRQ_ST, 32'h0);
    chk("status", rd[3:0], 32'h1);
    wb(1'h0, `ADR_RESULT, 32'h0);
    chk("result", {rd[9:5], rd[2:0]}, {1'h0, `AL_DI_ALARM, `TR_ALARM});
    chk("owner", rd[11:10], 32'h2);
    repeat (2) @(posedge clk_i);
    chk("irq clear", irq, 32'h0);
    $display("interrupt done");
    run_case(`MODE_ALARM, 1'h0, 1'h0, `CST_RUNNING, 2'h0);
    comm <= 2'h1;
    repeat (8) @(posedge clk_i);
    q.push_back(8'h0);
    repeat (4) @(posedge clk_i);
    $display("redundancy done");
    complete_run;
  end
endmodule // tb
